// ### hw/tta_thermal_assist.sv
`default_nettype none
// Overview of operation
// - crossing flag set by comparison, read-only
// - result-valid flag marks crossing flag meaningful
// - seven-bit threshold code, one degree steps
// - direction bit selects above or below
// - interrupt needs enable bit and crossing condition
// - without enable, flag still updates, no interrupt
// - invalid register takes no part
// - compare only when unit enabled, register valid
// - alternate thresholds when both valid
// - write to active register restarts, clears valid
// - control write clears both valid flags
// - wait sample interval cycles before latching
// - registers reached at special numbers 1020-1022
// - software cannot write status flags
module tta_thermal_assist (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic spr_priv,
    input wire logic spr_wr_en,
    input wire logic spr_rd_en,
    input wire logic [9:0] spr_num,
    input wire logic [31:0] spr_wdata,
    output logic [31:0] spr_rdata,
    output logic spr_rd_valid,
    input wire logic cmp_temp_above,
    output logic [6:0] dac_code,
    input wire logic global_external_irq_mask,
    output logic thermal_irq_req,
    output logic thermal_exc_req
);
    tta_smp_if smp_if ();

    logic [6:0] thr_code_q [2]; // threshold codes
    logic [1:0] dir_q; // compare_direction per register
    logic [1:0] ie_q; // thermal_irq_enable per register
    logic [1:0] valid_q; // register-valid per register
    logic [1:0] hit_q; // crossing_flag per register
    logic [1:0] rdy_q; // result_valid_flag per register
    logic [12:0] ivl_q; // sample_interval_count
    logic en_q; // unit enable
    logic alt_q; // alternation pointer in dual mode
    logic cmp_meta_q; // first synchroniser stage
    logic cmp_sync_q; // synchronised comparator output
    logic irq_q; // registered interrupt request
    logic [6:0] dac_q; // code presented to the DAC
    logic [31:0] rdata_q; // read data
    logic rd_valid_q; // read answer strobe
    logic wr_ok; // privileged write
    logic rd_ok; // privileged read
    logic [1:0] wr_thr; // write hits threshold register
    logic wr_ctrl; // write hits control register
    logic [1:0] restart_thr; // write to a register in use
    logic active_sel; // register being compared
    logic cross_now; // comparator read through direction bit
    logic [1:0] irq_src; // per-register request

    // decode of the privileged move instructions
    assign wr_ok = spr_wr_en & spr_priv;
    assign rd_ok = spr_rd_en & spr_priv;
    assign wr_thr[0] = wr_ok && (spr_num == tta_pkg::SPR_THR_FIRST);
    assign wr_thr[1] = wr_ok && (spr_num == tta_pkg::SPR_THR_SECOND);
    assign wr_ctrl = wr_ok && (spr_num == tta_pkg::SPR_UNIT_CTRL);

    // run only with the unit enabled and some register valid
    assign smp_if.run = en_q & (valid_q[0] | valid_q[1]);
    assign smp_if.interval = ivl_q;
    assign smp_if.restart = wr_ctrl | (|restart_thr);
    // dual mode alternates, single mode sticks to the valid one
    assign active_sel = (valid_q[0] & valid_q[1]) ? alt_q : ~valid_q[0];
    // direction clear: set when hotter; set: set when cooler
    assign cross_now = dir_q[active_sel] ? ~cmp_sync_q : cmp_sync_q;

    // per-register configuration and status
    for (genvar i = 0; i < 2; i++) begin : g_thr
        // a write to a register in the running comparison restarts it
        assign restart_thr[i] = wr_thr[i] & smp_if.run & valid_q[i];
        assign irq_src[i] = valid_q[i] & ie_q[i] & rdy_q[i] & hit_q[i];

        // settings: only defined fields are stored, reserved bits dropped
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                thr_code_q[i] <= tta_pkg::THR_RST[tta_pkg::THR_MSB:tta_pkg::THR_LSB];
                dir_q[i] <= tta_pkg::THR_RST[tta_pkg::DIR_BIT];
                ie_q[i] <= tta_pkg::THR_RST[tta_pkg::IE_BIT];
                valid_q[i] <= tta_pkg::THR_RST[tta_pkg::VALID_BIT];
            end else if (wr_thr[i]) begin
                thr_code_q[i] <= spr_wdata[tta_pkg::THR_MSB:tta_pkg::THR_LSB];
                dir_q[i] <= spr_wdata[tta_pkg::DIR_BIT];
                ie_q[i] <= spr_wdata[tta_pkg::IE_BIT];
                valid_q[i] <= spr_wdata[tta_pkg::VALID_BIT];
            end
        end

        // status flags: hardware only, write data never lands here
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                hit_q[i] <= tta_pkg::THR_RST[tta_pkg::HIT_BIT];
                rdy_q[i] <= tta_pkg::THR_RST[tta_pkg::RDY_BIT];
            end else if (wr_ctrl || restart_thr[i]) begin
                rdy_q[i] <= 1'b0;
            end else if (smp_if.sample && (active_sel == 1'(i))) begin
                hit_q[i] <= cross_now;
                rdy_q[i] <= 1'b1;
            end
        end
    end

    // unit control: interval and enable
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ivl_q <= tta_pkg::CTRL_RST[tta_pkg::IVL_MSB:tta_pkg::IVL_LSB];
            en_q <= tta_pkg::CTRL_RST[tta_pkg::EN_BIT];
        end else if (wr_ctrl) begin
            ivl_q <= spr_wdata[tta_pkg::IVL_MSB:tta_pkg::IVL_LSB];
            en_q <= spr_wdata[tta_pkg::EN_BIT];
        end
    end

    // alternation pointer: moves after each dual-mode sample
    always_ff @(posedge clk) begin
        if (sys_rst || wr_ctrl) begin
            alt_q <= 1'b0;
        end else if (smp_if.sample && valid_q[0] && valid_q[1]) begin
            alt_q <= ~alt_q;
        end
    end

    // comparator pin synchroniser
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            cmp_meta_q <= 1'b0;
            cmp_sync_q <= 1'b0;
        end else begin
            cmp_meta_q <= cmp_temp_above;
            cmp_sync_q <= cmp_meta_q;
        end
    end

    // DAC code follows the active register
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            dac_q <= 7'h00;
        end else begin
            dac_q <= thr_code_q[active_sel];
        end
    end

    // interrupt request, masked later by the processor
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |irq_src;
        end
    end

    // register read: one-cycle latency, unmapped numbers read zero
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rdata_q <= 32'h0000_0000;
            rd_valid_q <= 1'b0;
        end else begin
            rd_valid_q <= rd_ok;
            if (rd_ok) begin
                case (spr_num)
                    tta_pkg::SPR_THR_FIRST: begin
                        rdata_q <= {valid_q[0], ie_q[0], dir_q[0], 20'h00000, thr_code_q[0], rdy_q[0], hit_q[0]};
                    end
                    tta_pkg::SPR_THR_SECOND: begin
                        rdata_q <= {valid_q[1], ie_q[1], dir_q[1], 20'h00000, thr_code_q[1], rdy_q[1], hit_q[1]};
                    end
                    tta_pkg::SPR_UNIT_CTRL: begin
                        rdata_q <= {en_q, ivl_q, 18'h00000};
                    end
                    default: begin
                        rdata_q <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    assign spr_rdata = rdata_q;
    assign spr_rd_valid = rd_valid_q;
    assign dac_code = dac_q;
    assign thermal_irq_req = irq_q;
    assign thermal_exc_req = irq_q & global_external_irq_mask;

    tta_sampler u_sampler (
        .clk(clk),
        .sys_rst(sys_rst),
        .smp(smp_if.smp)
    );

    chk_ready_cause: assert property (@(posedge clk) disable iff (sys_rst)
        $rose(rdy_q[0]) |-> $past(smp_if.sample) && !$past(active_sel))
        else $error("first valid flag rose without a sample");
    chk_irq_cause: assert property (@(posedge clk) disable iff (sys_rst)
        thermal_irq_req |-> $past(|(valid_q & ie_q & hit_q & rdy_q)))
        else $error("interrupt without enabled crossing");
    chk_exc_mask: assert property (@(posedge clk) disable iff (sys_rst)
        thermal_exc_req |-> global_external_irq_mask && thermal_irq_req)
        else $error("exception request not masked");
    chk_ctrl_clears: assert property (@(posedge clk) disable iff (sys_rst)
        wr_ctrl |=> (rdy_q == 2'b00))
        else $error("control write left a valid flag");
    chk_thr_restart: assert property (@(posedge clk) disable iff (sys_rst)
        (restart_thr[1] && smp_if.interval > 13'h0001) |=> !rdy_q[1] && !smp_if.sample)
        else $error("write to active register did not restart");
    chk_idle_stop: assert property (@(posedge clk) disable iff (sys_rst)
        (!en_q || valid_q == 2'b00) |=> !$rose(rdy_q[0]) && !$rose(rdy_q[1]))
        else $error("result produced while unit stopped");
    chk_single_dac: assert property (@(posedge clk) disable iff (sys_rst)
        (valid_q == 2'b10) |=> dac_code == $past(thr_code_q[1]))
        else $error("single mode drove the wrong threshold");
    chk_alternate: assert property (@(posedge clk) disable iff (sys_rst)
        (smp_if.sample && valid_q == 2'b11 && !wr_ctrl) |=> alt_q != $past(alt_q))
        else $error("dual mode did not alternate");
    chk_reset_clear: assert property (@(posedge clk)
        sys_rst |=> (rdy_q == 2'b00) && (valid_q == 2'b00) && !en_q && !thermal_irq_req)
        else $error("reset left state set");
    cov_first_sample: cover property (@(posedge clk) disable iff (sys_rst) smp_if.sample && !active_sel);
    cov_second_sample: cover property (@(posedge clk) disable iff (sys_rst) smp_if.sample && active_sel);
    cov_irq_rise: cover property (@(posedge clk) disable iff (sys_rst) $rose(thermal_irq_req));
    cov_dual_alt: cover property (@(posedge clk) disable iff (sys_rst) smp_if.sample && valid_q == 2'b11);
endmodule
`default_nettype wire

// ### hw/tta_pkg.sv
`default_nettype none
// shared constants of the thermal threshold assist
package tta_pkg;
    // special-register numbers of the three thermal registers
    localparam logic [9:0] SPR_THR_FIRST = 10'h3FC;
    localparam logic [9:0] SPR_THR_SECOND = 10'h3FD;
    localparam logic [9:0] SPR_UNIT_CTRL = 10'h3FE;
    // threshold register fields
    localparam int HIT_BIT = 0; // crossing_flag
    localparam int RDY_BIT = 1; // result_valid_flag
    localparam int THR_LSB = 2;
    localparam int THR_MSB = 8;
    localparam int THR_W = 7;
    localparam int DIR_BIT = 29;
    localparam int IE_BIT = 30;
    localparam int VALID_BIT = 31;
    // unit control register fields
    localparam int IVL_LSB = 18; // sample_interval_count
    localparam int IVL_MSB = 30;
    localparam int IVL_W = 13;
    localparam int EN_BIT = 31;
    // reset values
    localparam logic [31:0] THR_RST = 32'h0000_0000;
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    // suggested interval: 20 us at a 100 ns clock
    localparam int SAMPLE_TIME_NS = 20000;
    localparam int CLK_PERIOD_NS = 100;
    localparam logic [12:0] IVL_SUGGESTED = 13'(SAMPLE_TIME_NS / CLK_PERIOD_NS);
    // sampler states, one-hot
    typedef enum logic [1:0] {
        SMP_IDLE = 2'b01,
        SMP_COUNT = 2'b10
    } tta_smp_state_t;
endpackage
`default_nettype wire

// ### hw/tta_smp_if.sv
`default_nettype none
// link between the register logic and the sample-interval timer
interface tta_smp_if;
    logic run;                           // comparison allowed
    logic restart;                       // restart the running comparison
    logic [tta_pkg::IVL_W-1:0] interval; // cycles per comparison
    logic sample;                        // one-cycle pulse: latch comparator now
    logic busy;                          // timer is counting
    modport main (output run, output restart, output interval, input sample, input busy);
    modport smp (input run, input restart, input interval, output sample, output busy);
endinterface
`default_nettype wire

// ### hw/tta_sampler.sv
`default_nettype none
// counts the sample interval and fires one sample pulse per comparison
module tta_sampler (
    input wire logic clk,
    input wire logic sys_rst,
    tta_smp_if.smp smp
);
    tta_pkg::tta_smp_state_t state_q; // idle or counting
    logic [12:0] cnt_q; // cycles since the comparison started
    logic done; // interval has elapsed

    // interval of 0 or 1 samples every counting cycle
    assign done = (state_q == tta_pkg::SMP_COUNT) && (({1'b0, cnt_q} + 14'h0001) >= {1'b0, smp.interval});
    // a restart discards the comparison in flight
    assign smp.sample = done & smp.run & ~smp.restart;
    assign smp.busy = (state_q == tta_pkg::SMP_COUNT);

    // state: start counting once the unit may run
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            state_q <= tta_pkg::SMP_IDLE;
        end else begin
            case (state_q)
                tta_pkg::SMP_IDLE: begin
                    if (smp.run && !smp.restart) begin
                        state_q <= tta_pkg::SMP_COUNT;
                    end
                end
                tta_pkg::SMP_COUNT: begin
                    // stop as soon as the unit is disabled or no register is valid
                    if (!smp.run) begin
                        state_q <= tta_pkg::SMP_IDLE;
                    end
                end
                default: begin
                    state_q <= tta_pkg::SMP_IDLE;
                end
            endcase
        end
    end

    // counter: cleared on restart, on each sample and while idle
    always_ff @(posedge clk) begin
        if (sys_rst || smp.restart || !smp.run || (state_q != tta_pkg::SMP_COUNT) || smp.sample) begin
            cnt_q <= 13'h0000;
        end else begin
            cnt_q <= cnt_q + 13'h0001;
        end
    end

    chk_sample_gap: assert property (@(posedge clk) disable iff (sys_rst)
        (smp.sample && smp.interval > 13'h0001 && !smp.restart) |=> !smp.sample)
        else $error("sample pulses closer than the interval");
    chk_sample_in_run: assert property (@(posedge clk) disable iff (sys_rst)
        smp.sample |-> (smp.run && smp.busy))
        else $error("sample fired while the unit was stopped");
endmodule
`default_nettype wire

// ### bench/tta_sensor_model.sv
`default_nettype none
// sensor, dac and comparator as seen from the assist logic
module tta_sensor_model (
    input wire logic clk,
    input wire logic [6:0] dac_code,
    input wire logic [6:0] temp,
    output logic cmp_temp_above
);
    timeunit 1ns;
    timeprecision 1ns;
    // comparator output settles one cycle after the dac code moves
    always_ff @(posedge clk) begin
        cmp_temp_above <= (temp > dac_code);
    end
endmodule
`default_nettype wire

// ### bench/tta_thermal_assist_tb.sv
`default_nettype none
// register-level checks of the thermal assist
module tta_thermal_assist_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0; // 10 MHz
    logic sys_rst = 1'b1;
    logic spr_priv = 1'b1;
    logic spr_wr_en = 1'b0;
    logic spr_rd_en = 1'b0;
    logic [9:0] spr_num = 10'h000;
    logic [31:0] spr_wdata = 32'h0000_0000;
    logic [31:0] spr_rdata;
    logic spr_rd_valid;
    logic cmp_temp_above;
    logic [6:0] dac_code;
    logic mask = 1'b0; // global interrupt mask
    logic irq;
    logic exc;
    logic [6:0] temp = 7'h32; // junction at 50 degrees
    logic [31:0] v;
    int n_fail = 0;
    int checks = 0;
    int cyc = 0;
    int n_a = 0;
    int n_b = 0;
    localparam logic [31:0] EN = 32'h8000_0000; // unit enable
    localparam logic [31:0] IV10 = 32'h0028_0000; // interval of 10 cycles

    // threshold register image: valid, irq enable, direction, code
    function automatic logic [31:0] thr(logic ie, logic dir, logic [6:0] t);
        return {1'b1, ie, dir, 20'h00000, t, 2'b00};
    endfunction

    always #50 clk = ~clk;

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            test_done();
        end
    end

    tta_sensor_model u_sensor (.clk(clk), .dac_code(dac_code), .temp(temp), .cmp_temp_above(cmp_temp_above));

    tta_thermal_assist dut (
        .clk(clk),
        .sys_rst(sys_rst),
        .spr_priv(spr_priv),
        .spr_wr_en(spr_wr_en),
        .spr_rd_en(spr_rd_en),
        .spr_num(spr_num),
        .spr_wdata(spr_wdata),
        .spr_rdata(spr_rdata),
        .spr_rd_valid(spr_rd_valid),
        .cmp_temp_above(cmp_temp_above),
        .dac_code(dac_code),
        .global_external_irq_mask(mask),
        .thermal_irq_req(irq),
        .thermal_exc_req(exc)
    );

    // compare and count
    task automatic chk(logic [31:0] got, logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask

    // one move-to-register access
    task automatic wr(logic [9:0] n, logic [31:0] d);
        @(posedge clk);
        spr_wr_en <= 1'b1;
        spr_num <= n;
        spr_wdata <= d;
        @(posedge clk);
        spr_wr_en <= 1'b0;
    endtask

    // one move-from-register access, answer one cycle after it is taken
    task automatic rd(logic [9:0] n, output logic [31:0] d);
        @(posedge clk);
        spr_rd_en <= 1'b1;
        spr_num <= n;
        @(posedge clk);
        spr_rd_en <= 1'b0;
        #1;
        chk({31'h0, spr_rd_valid}, 32'h1);
        d = spr_rdata;
    endtask

    task automatic rdchk(logic [9:0] n, logic [31:0] e);
        rd(n, v);
        chk(v, e);
    endtask

    task automatic idle(int k);
        repeat (k) @(posedge clk);
    endtask

    // verdict
    task automatic test_done();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // dac code occupancy while both thresholds are in use
    always @(posedge clk) begin
        if (dac_code === 7'h28) n_a++;
        if (dac_code === 7'h3C) n_b++;
    end

    initial begin
        idle(2);
        sys_rst <= 1'b0;
        // reset values, field access kinds, unmapped accesses and an unprivileged write
        rdchk(tta_pkg::SPR_THR_FIRST, 32'h0);
        rdchk(tta_pkg::SPR_THR_SECOND, 32'h0);
        rdchk(tta_pkg::SPR_UNIT_CTRL, 32'h0);
        // reserved bits written as zeros; status bits written as ones must not land
        wr(tta_pkg::SPR_THR_SECOND, 32'hE000_01FF);
        rdchk(tta_pkg::SPR_THR_SECOND, 32'hE000_01FC);
        wr(tta_pkg::SPR_UNIT_CTRL, 32'h7FFC_0000);
        rdchk(tta_pkg::SPR_UNIT_CTRL, 32'h7FFC_0000);
        wr(10'h3FB, 32'hFFFF_FFFF);
        rdchk(10'h3FB, 32'h0);
        spr_priv <= 1'b0;
        wr(tta_pkg::SPR_UNIT_CTRL, EN);
        spr_priv <= 1'b1;
        rdchk(tta_pkg::SPR_UNIT_CTRL, 32'h7FFC_0000);
        wr(tta_pkg::SPR_THR_SECOND, 32'h0);
        $display("test access done");
        // single threshold at 40 for every direction and enable pair
        for (int i = 0; i < 4; i++) begin
            wr(tta_pkg::SPR_THR_FIRST, thr(i[0], i[1], 7'h28));
            wr(tta_pkg::SPR_UNIT_CTRL, EN | IV10);
            idle(30);
            chk({25'h0, dac_code}, 32'h28);
            rdchk(tta_pkg::SPR_THR_FIRST, thr(i[0], i[1], 7'h28) | {30'h0, 1'b1, !i[1]});
            chk({31'h0, irq}, {31'h0, i[0] & !i[1]});
            chk({31'h0, exc}, 32'h0);
        end
        $display("test single done");
        // interrupt, then restart by register and by control writes
        wr(tta_pkg::SPR_THR_FIRST, thr(1'b1, 1'b0, 7'h28));
        idle(30);
        mask <= 1'b1;
        idle(1);
        #1;
        chk({30'h0, irq, exc}, 32'h3);
        wr(tta_pkg::SPR_THR_FIRST, thr(1'b1, 1'b0, 7'h28));
        rd(tta_pkg::SPR_THR_FIRST, v);
        chk(v & 32'hFFFF_FFFE, thr(1'b1, 1'b0, 7'h28));
        chk({31'h0, irq}, 32'h0);
        idle(30);
        wr(tta_pkg::SPR_UNIT_CTRL, EN | IV10);
        rd(tta_pkg::SPR_THR_FIRST, v);
        chk(v & 32'hFFFF_FFFE, thr(1'b1, 1'b0, 7'h28));
        mask <= 1'b0;
        $display("test restart done");
        // long interval: no result before it runs out
        wr(tta_pkg::SPR_UNIT_CTRL, {1'b1, tta_pkg::IVL_SUGGESTED, 18'h00000});
        idle(150);
        rd(tta_pkg::SPR_THR_FIRST, v);
        chk(v & 32'h2, 32'h0);
        idle(60);
        rd(tta_pkg::SPR_THR_FIRST, v);
        chk(v & 32'h2, 32'h2);
        $display("test interval done");
        // both thresholds valid: 40 below and 60 above the junction
        wr(tta_pkg::SPR_THR_FIRST, thr(1'b0, 1'b0, 7'h28));
        wr(tta_pkg::SPR_THR_SECOND, thr(1'b0, 1'b0, 7'h3C));
        wr(tta_pkg::SPR_UNIT_CTRL, EN | IV10);
        n_a = 0;
        n_b = 0;
        idle(100);
        chk({31'h0, n_a > 20 && n_b > 20}, 32'h1);
        rdchk(tta_pkg::SPR_THR_FIRST, thr(1'b0, 1'b0, 7'h28) | 32'h3);
        rdchk(tta_pkg::SPR_THR_SECOND, thr(1'b0, 1'b0, 7'h3C) | 32'h2);
        $display("test dual done");
        // no valid register, then unit disabled
        wr(tta_pkg::SPR_THR_FIRST, 32'h0);
        wr(tta_pkg::SPR_THR_SECOND, 32'h0);
        wr(tta_pkg::SPR_UNIT_CTRL, EN | IV10);
        idle(30);
        // crossing flag keeps its stale value while result-valid is clear
        rd(tta_pkg::SPR_THR_FIRST, v);
        chk(v & 32'hFFFF_FFFE, 32'h0);
        wr(tta_pkg::SPR_UNIT_CTRL, 32'h0);
        wr(tta_pkg::SPR_THR_FIRST, thr(1'b0, 1'b0, 7'h28));
        idle(30);
        rd(tta_pkg::SPR_THR_FIRST, v);
        chk(v & 32'hFFFF_FFFE, thr(1'b0, 1'b0, 7'h28));
        // reset again in mid-run
        wr(tta_pkg::SPR_UNIT_CTRL, EN | IV10);
        idle(30);
        sys_rst <= 1'b1;
        idle(2);
        sys_rst <= 1'b0;
        rdchk(tta_pkg::SPR_THR_FIRST, 32'h0);
        rdchk(tta_pkg::SPR_UNIT_CTRL, 32'h0);
        $display("test disable done");
        test_done();
    end
endmodule
`default_nettype wire
